/* src/pass_through_cmd.sv */
// pass-through command interpreter: parses a host packet byte stream,
// runs a secondary bus transfer and streams back the result packet
// assumes a byte-wide host stream and an external bus phy per byte
//
// Overview of operation
// - bytes 0-1 hold command code 000A
// - bytes 2-3 count following bytes, padded
// - bytes 4-5 are the mode word
// - bytes 6-7 spi rate kHz, low first
// - i2c ignores requested rate, uses configured
// - spi clock divides oscillator, 2 to 32
// - unmatched rate picks next slower divisor
// - byte 8 format byte or sensor id
// - byte 9 i2c address or cs gpio
// - byte 10 transfer count, max 244
// - byte 11 starting register address
// - write payload from byte 12, writes only
// - bit0 direction, bit1 burst or singles
// - bit2 enables inter-byte delay
// - bits 3-4 select driver or bus
// - bit5 picks three-wire spi
// - bits 6-7 clock polarity and phase
// - bits 8-13 delay in 50 us units
// - bit14 chip select active level
// - bit15 shifts spi low bit first
// - result packet 0005, status one or two
// - i2c read: address, repeated start, read
// - command byte: shifted address plus read flag
module pass_through_cmd
  import pass_through_pkg::*;
#(
  parameter int OSC_KHZ = 20000
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_first,
  output logic            in_ready,
  output logic            out_valid,
  output logic [7:0]      out_byte,
  output logic            out_last,
  input  wire logic       out_ready,
  input  wire logic [3:0] bus_is_i2c,
  input  wire logic       drv_is_i2c,
  input  wire logic       drv_three_wire,
  input  wire logic       drv_cpol,
  input  wire logic       drv_cpha,
  input  wire logic       drv_cs_high,
  input  wire logic       drv_low_bit_first,
  output logic            byte_req,
  output logic [7:0]      byte_out,
  output logic            byte_last,
  output logic            byte_restart,
  output logic [1:0]      bus_select,
  output logic            spi_three_wire,
  output logic            spi_cpol,
  output logic            spi_cpha,
  output logic            spi_cs_high,
  output logic            spi_low_bit_first,
  output logic [5:0]      spi_divisor,
  output logic [7:0]      sensor_id,
  output logic [7:0]      target,
  output logic            bad_command,
  input  wire logic       byte_ack,
  input  wire logic       byte_nack,
  input  wire logic [7:0] byte_in
);

  typedef enum {S_HEAD, S_PAYLOAD, S_SKIP, S_RUN, S_REPLY} top_state_t;
  top_state_t state;

  bus_job_if job ();

  logic [7:0]  pos;
  logic [15:0] cmd_code;
  logic [15:0] length;
  logic [15:0] mode;
  logic [15:0] rate_khz;
  logic [7:0]  fmt;
  logic [7:0]  count;
  logic [7:0]  reg_addr;
  logic [7:0]  wr_mem [MAX_XFER_BYTES];
  logic [7:0]  rd_mem [MAX_XFER_BYTES];
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_idx_rd;
  logic [7:0]  result;
  logic [7:0]  out_pos;
  logic [7:0]  reply_len;
  logic        is_i2c;
  logic [7:0]  cmd_byte;
  logic [5:0]  div_pick;
  bus_sel_t    bus;

  assign bus = bus_sel_t'(mode[MODE_BUS_LO +: 2]);
  assign is_i2c = (bus == BUS_DRIVER) ? drv_is_i2c : bus_is_i2c[bus];

  ////////////////////////////////////////////////////////////////////////
  // command byte and clock divisor
  always_comb
  begin
    logic [7:0] rd_bit;
    rd_bit   = 8'h01 << fmt[FMT_READ_POS +: 3];
    cmd_byte = reg_addr << fmt[FMT_SHIFT_LO +: 4];
    // read flag polarity comes from the format byte
    if (mode[MODE_DIR] ^ fmt[FMT_READ_POL])
      cmd_byte = cmd_byte | rd_bit;
    else
      cmd_byte = cmd_byte & ~rd_bit;
  end

  // slowest divisor is the fallback when nothing fits below the request
  always_comb
  begin
    div_pick = DIVISORS[NUM_DIVISORS - 1];
    for (int i = NUM_DIVISORS - 1; i >= 0; i--)
      if (32'(OSC_KHZ) / 32'(DIVISORS[i]) <= 32'(rate_khz))
        div_pick = DIVISORS[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // packet parsing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= S_HEAD;
      pos         <= 8'h00;
      cmd_code    <= 16'h0000;
      length      <= 16'h0000;
      mode        <= 16'h0000;
      rate_khz    <= 16'h0000;
      fmt         <= 8'h00;
      count       <= 8'h00;
      reg_addr    <= 8'h00;
      target      <= 8'h00;
      bad_command <= 1'b0;
      in_ready    <= 1'b0;
      wr_idx      <= 8'h00;
      out_pos     <= 8'h00;
      out_valid   <= 1'b0;
      out_byte    <= 8'h00;
      out_last    <= 1'b0;
    end
    else
    begin
      in_ready <= (state == S_HEAD) || (state == S_PAYLOAD)
                  || (state == S_SKIP);
      case (state)
        S_HEAD:
        begin
          // a refused bare header flags for one cycle only
          bad_command <= 1'b0;
          if (in_valid && in_ready)
          begin
            pos <= in_first ? 8'h01 : pos + 8'h01;
            case (in_first ? OFS_CMD_LO : pos)
              OFS_CMD_LO:  cmd_code[7:0]  <= in_byte;
              OFS_CMD_HI:  cmd_code[15:8] <= in_byte;
              OFS_LEN_LO:  length[7:0]    <= in_byte;
              OFS_LEN_HI:  length[15:8]   <= in_byte;
              OFS_MODE_LO: mode[7:0]      <= in_byte;
              OFS_MODE_HI: mode[15:8]     <= in_byte;
              OFS_RATE_LO: rate_khz[7:0]  <= in_byte;
              OFS_RATE_HI: rate_khz[15:8] <= in_byte;
              OFS_FORMAT:  fmt            <= in_byte;
              OFS_TARGET:  target         <= in_byte;
              OFS_COUNT:   count          <= in_byte;
              OFS_REG:
              begin
                reg_addr <= in_byte;
                wr_idx   <= 8'h00;
                if (cmd_code != CMD_PASS_THROUGH
                    || count > MAX_XFER_BYTES)
                begin
                  bad_command <= 1'b1;
                  // a bare header leaves no filler to drop
                  state <= (length > 16'(OFS_PAYLOAD - HEADER_BYTES))
                           ? S_SKIP : S_HEAD;
                end
                else if (mode[MODE_DIR] && count != 8'h00)
                  state <= S_PAYLOAD;
                else
                  state <= (length > 16'(OFS_PAYLOAD - HEADER_BYTES))
                           ? S_SKIP : S_RUN;
              end
              default: ;
            endcase
          end
        end
        S_PAYLOAD:
          if (in_valid && in_ready)
          begin
            pos    <= pos + 8'h01;
            wr_idx <= wr_idx + 8'h01;
            if (wr_idx == count - 8'h01)
              state <= ((16'(pos) + 16'h0001) >= length + 16'(HEADER_BYTES))
                       ? S_RUN : S_SKIP;
          end
        S_SKIP:
          // filler bytes up to the length field are dropped
          if (in_valid && in_ready)
          begin
            pos <= pos + 8'h01;
            if ((16'(pos) + 16'h0001) >= length + 16'(HEADER_BYTES))
            begin
              state <= bad_command ? S_HEAD : S_RUN;
              bad_command <= 1'b0;
            end
          end
        S_RUN:
          if (job.done)
          begin
            state   <= S_REPLY;
            out_pos <= 8'h00;
          end
        S_REPLY:
          if (!out_valid || out_ready)
          begin
            out_valid <= 1'b1;
            out_last  <= (out_pos == reply_len - 8'h01);
            case (out_pos)
              8'h00: out_byte <= STATUS_PASS_RESULT[7:0];
              8'h01: out_byte <= STATUS_PASS_RESULT[15:8];
              8'h02: out_byte <= reply_len - HEADER_BYTES;
              8'h03: out_byte <= 8'h00;
              8'h04: out_byte <= result;
              8'h05: out_byte <= mode[7:0];
              8'h06: out_byte <= mode[15:8];
              8'h07: out_byte <= is_i2c ? 8'h00 : rate_khz[7:0];
              8'h08: out_byte <= is_i2c ? 8'h00 : rate_khz[15:8];
              8'h09: out_byte <= fmt;
              8'h0A: out_byte <= target;
              8'h0B: out_byte <= count;
              8'h0C: out_byte <= reg_addr;
              default: out_byte <= (!mode[MODE_DIR]
                                    && out_pos - 8'h0D < count)
                                   ? rd_mem[out_pos - 8'h0D] : 8'h00;
            endcase
            out_pos <= out_pos + 8'h01;
            if (out_pos == reply_len)
            begin
              out_valid <= 1'b0;
              out_last  <= 1'b0;
              state     <= S_HEAD;
            end
          end
        default: state <= S_HEAD;
      endcase
    end
  end

  // reply grows by read data and pads to a four-byte multiple
  always_comb
  begin
    logic [8:0] raw;
    raw = 9'h00D + (mode[MODE_DIR] ? 9'h000 : 9'(count));
    reply_len = 8'((raw + 9'h003) & 9'h1FC);
  end

  ////////////////////////////////////////////////////////////////////////
  // payload and read-data stores
  always_ff @(posedge clk)
  begin
    if (state == S_PAYLOAD && in_valid && in_ready)
      wr_mem[wr_idx] <= in_byte;
    if (job.rd_valid)
      rd_mem[rd_idx] <= job.rd_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_idx <= 8'h00;
    else if (job.start)
      rd_idx <= 8'h00;
    else if (job.rd_valid)
      rd_idx <= rd_idx + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // job launch and bus configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      job.start         <= 1'b0;
      result            <= DONE_OK;
      bus_select        <= 2'h0;
      spi_three_wire    <= 1'b0;
      spi_cpol          <= 1'b0;
      spi_cpha          <= 1'b0;
      spi_cs_high       <= 1'b0;
      spi_low_bit_first <= 1'b0;
      spi_divisor       <= DIVISORS[0];
      sensor_id         <= 8'h00;
    end
    else
    begin
      job.start <= 1'b0;
      // result holds FF from launch to done: one job per packet
      if (state == S_RUN && !job.busy && !job.done && !job.start
          && result != 8'hFF)
      begin
        job.start  <= 1'b1;
        result     <= 8'hFF;
        bus_select <= mode[MODE_BUS_LO +: 2];
        if (bus == BUS_DRIVER)
        begin
          // spi details come from the built-in driver
          spi_three_wire    <= drv_three_wire;
          spi_cpol          <= drv_cpol;
          spi_cpha          <= drv_cpha;
          spi_cs_high       <= drv_cs_high;
          spi_low_bit_first <= drv_low_bit_first;
          sensor_id         <= fmt;
        end
        else
        begin
          spi_three_wire    <= mode[MODE_THREE_W];
          spi_cpol          <= mode[MODE_CPOL];
          spi_cpha          <= mode[MODE_CPHA];
          spi_cs_high       <= mode[MODE_CS_HIGH];
          spi_low_bit_first <= mode[MODE_LOW_BIT];
        end
        // i2c keeps its configured rate
        if (!is_i2c)
          spi_divisor <= div_pick;
      end
      if (job.done)
        result <= (is_i2c && job.fail) ? DONE_I2C_FAIL : DONE_OK;
      if (state == S_REPLY && out_pos == reply_len)
        result <= DONE_OK;
    end
  end

  assign job.is_i2c        = is_i2c;
  assign job.write         = mode[MODE_DIR];
  assign job.singles       = mode[MODE_SINGLES];
  assign job.gap_en        = mode[MODE_DELAY]
                             && mode[MODE_DLY_LO +: 6] >= DELAY_MIN_UNITS;
  assign job.gap_units     = mode[MODE_DLY_LO +: 6];
  assign job.three_wire    = spi_three_wire;
  assign job.cpol          = spi_cpol;
  assign job.cpha          = spi_cpha;
  assign job.cs_high       = spi_cs_high;
  assign job.low_bit_first = spi_low_bit_first;
  assign job.divisor       = spi_divisor;
  assign job.cmd_byte      = cmd_byte;
  assign job.target        = reg_addr;
  assign job.count         = count;
  assign job.wr_data       = wr_mem[wr_idx_rd];

  always_ff @(posedge clk)
  begin
    if (!rst_n || job.start)
      wr_idx_rd <= 8'h00;
    else if (job.wr_take)
      wr_idx_rd <= wr_idx_rd + 8'h01;
  end

  bus_engine u_engine (
    .clk          (clk),
    .rst_n        (rst_n),
    .job          (job.engine),
    .byte_req     (byte_req),
    .byte_out     (byte_out),
    .byte_last    (byte_last),
    .byte_restart (byte_restart),
    .byte_ack     (byte_ack),
    .byte_nack    (byte_nack),
    .byte_in      (byte_in)
  );

endmodule // pass_through_cmd

/* common/pass_through_pkg.sv */
// constants and types for the pass-through command interpreter
// assumes a single 25 MHz clock domain
package pass_through_pkg;

  localparam logic [15:0] CMD_PASS_THROUGH  = 16'h000A;
  localparam logic [15:0] STATUS_PASS_RESULT = 16'h0005;
  localparam logic [7:0]  DONE_OK           = 8'h01;
  localparam logic [7:0]  DONE_I2C_FAIL     = 8'h02;
  localparam logic [7:0]  MAX_XFER_BYTES    = 8'hF4;

  // byte offsets inside the command packet
  localparam logic [7:0] OFS_CMD_LO   = 8'h00;
  localparam logic [7:0] OFS_CMD_HI   = 8'h01;
  localparam logic [7:0] OFS_LEN_LO   = 8'h02;
  localparam logic [7:0] OFS_LEN_HI   = 8'h03;
  localparam logic [7:0] OFS_MODE_LO  = 8'h04;
  localparam logic [7:0] OFS_MODE_HI  = 8'h05;
  localparam logic [7:0] OFS_RATE_LO  = 8'h06;
  localparam logic [7:0] OFS_RATE_HI  = 8'h07;
  localparam logic [7:0] OFS_FORMAT   = 8'h08;
  localparam logic [7:0] OFS_TARGET   = 8'h09;
  localparam logic [7:0] OFS_COUNT    = 8'h0A;
  localparam logic [7:0] OFS_REG      = 8'h0B;
  localparam logic [7:0] OFS_PAYLOAD  = 8'h0C;
  localparam logic [7:0] HEADER_BYTES = 8'h04;

  // mode word fields
  localparam int MODE_DIR     = 0;
  localparam int MODE_SINGLES = 1;
  localparam int MODE_DELAY   = 2;
  localparam int MODE_BUS_LO  = 3;
  localparam int MODE_THREE_W = 5;
  localparam int MODE_CPOL    = 6;
  localparam int MODE_CPHA    = 7;
  localparam int MODE_DLY_LO  = 8;
  localparam int MODE_CS_HIGH = 14;
  localparam int MODE_LOW_BIT = 15;
  localparam logic [5:0] DELAY_MIN_UNITS = 6'h04;

  // command-byte format fields
  localparam int FMT_SHIFT_LO = 0;
  localparam int FMT_READ_POL = 4;
  localparam int FMT_READ_POS = 5;

  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int DELAY_UNIT_US = 50;
  localparam int DELAY_UNIT_CYC = (CLK_HZ / 1_000_000) * DELAY_UNIT_US;

  localparam int NUM_DIVISORS = 7;
  typedef logic [5:0] divisor_t;
  localparam divisor_t DIVISORS [NUM_DIVISORS] =
    '{6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};

  typedef enum logic [1:0] {BUS_DRIVER, BUS_ONE, BUS_TWO, BUS_THREE} bus_sel_t;

endpackage

/* common/bus_job_if.sv */
// job request and answer between the interpreter and the bus engine
// assumes both ends share clk
interface bus_job_if;
  logic       start;
  logic       busy;
  logic       done;
  logic       fail;
  logic       is_i2c;
  logic       write;
  logic       singles;
  logic       gap_en;
  logic [5:0] gap_units;
  logic       three_wire;
  logic       cpol;
  logic       cpha;
  logic       cs_high;
  logic       low_bit_first;
  logic [5:0] divisor;
  logic [7:0] cmd_byte;
  logic [7:0] target;
  logic [7:0] count;
  logic [7:0] wr_data;
  logic       wr_take;
  logic [7:0] rd_data;
  logic       rd_valid;

  modport ctrl (output start, is_i2c, write, singles, gap_en, gap_units,
                three_wire, cpol, cpha, cs_high, low_bit_first, divisor,
                cmd_byte, target, count, wr_data,
                input busy, done, fail, wr_take, rd_data, rd_valid);
  modport engine (input start, is_i2c, write, singles, gap_en, gap_units,
                  three_wire, cpol, cpha, cs_high, low_bit_first, divisor,
                  cmd_byte, target, count, wr_data,
                  output busy, done, fail, wr_take, rd_data, rd_valid);
endinterface

/* src/bus_engine.sv */
// byte sequencer for one pass-through job on a secondary bus
// assumes the interpreter holds job fields stable while busy
module bus_engine
  import pass_through_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  bus_job_if.engine job,
  output logic      byte_req,
  output logic [7:0] byte_out,
  output logic      byte_last,
  output logic      byte_restart,
  input  wire logic byte_ack,
  input  wire logic byte_nack,
  input  wire logic [7:0] byte_in
);

  typedef enum {E_IDLE, E_ADDR, E_WAIT_ADDR, E_DATA, E_WAIT_DATA,
                E_GAP} eng_state_t;
  eng_state_t state;
  logic [7:0]  left;
  logic [16:0] gap_cnt; // longest gap of 63 units needs 17 bits
  logic        failed;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state        <= E_IDLE;
      left         <= 8'h00;
      gap_cnt      <= 17'h00000;
      failed       <= 1'b0;
      byte_req     <= 1'b0;
      byte_out     <= 8'h00;
      byte_last    <= 1'b0;
      byte_restart <= 1'b0;
      job.busy     <= 1'b0;
      job.done     <= 1'b0;
      job.fail     <= 1'b0;
      job.wr_take  <= 1'b0;
      job.rd_data  <= 8'h00;
      job.rd_valid <= 1'b0;
    end
    else
    begin
      job.done     <= 1'b0;
      job.wr_take  <= 1'b0;
      job.rd_valid <= 1'b0;
      byte_req     <= 1'b0;
      case (state)
        E_IDLE:
          if (job.start)
          begin
            job.busy <= 1'b1;
            failed   <= 1'b0;
            left     <= job.count;
            // register address or formatted command byte goes first
            byte_out     <= job.is_i2c ? job.target : job.cmd_byte;
            byte_req     <= 1'b1;
            byte_restart <= 1'b0;
            byte_last    <= (job.count == 8'h00);
            state        <= E_WAIT_ADDR;
          end
        E_WAIT_ADDR:
          if (byte_ack || byte_nack)
          begin
            failed <= failed | byte_nack;
            state  <= (left == 8'h00) ? E_IDLE : E_DATA;
            if (left == 8'h00)
            begin
              job.busy <= 1'b0;
              job.done <= 1'b1;
              job.fail <= failed | byte_nack;
            end
          end
        E_DATA:
        begin
          byte_out <= job.write ? job.wr_data : 8'h00;
          job.wr_take <= job.write;
          // i2c reads turn round with a repeated start
          byte_restart <= !job.write && job.is_i2c && (left == job.count);
          byte_last <= (left == 8'h01) || job.singles;
          byte_req  <= 1'b1;
          state     <= E_WAIT_DATA;
        end
        E_WAIT_DATA:
          if (byte_ack || byte_nack)
          begin
            failed <= failed | byte_nack;
            if (!job.write)
            begin
              job.rd_data  <= byte_in;
              job.rd_valid <= 1'b1;
            end
            left    <= left - 8'h01;
            gap_cnt <= 17'(job.gap_units) * 17'(DELAY_UNIT_CYC);
            if (left == 8'h01)
            begin
              state    <= E_IDLE;
              job.busy <= 1'b0;
              job.done <= 1'b1;
              job.fail <= failed | byte_nack;
            end
            else
              state <= job.gap_en ? E_GAP : E_DATA;
          end
        E_GAP:
          if (gap_cnt <= 17'h00001)
            state <= E_DATA;
          else
            gap_cnt <= gap_cnt - 17'h00001;
        default: state <= E_IDLE;
      endcase
    end
  end

endmodule // bus_engine

/* tb/phy_model.sv */
// bus phy model: answers each byte request three cycles later
// assumes the bench sets nack_on and rd_val between jobs
module phy_model
(
  input  wire logic       clk,
  input  wire logic       byte_req,
  input  wire logic       nack_on,
  input  wire logic [7:0] rd_val,
  output logic            byte_ack,
  output logic            byte_nack,
  output logic [7:0]      byte_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt = 2'h0;
  initial
  begin
    byte_ack = 1'b0;
    byte_nack = 1'b0;
    byte_in = 8'h00;
  end
  always @(posedge clk)
  begin
    byte_ack <= 1'b0;
    byte_nack <= 1'b0;
    // data not under ack or nack is inverted so stale bytes never match
    byte_in <= ~rd_val;
    if (byte_req)
      wait_cnt <= 2'h3;
    else if (wait_cnt != 2'h0)
      wait_cnt <= wait_cnt - 2'h1;
    if (!byte_req && wait_cnt == 2'h1)
    begin
      byte_ack <= !nack_on;
      byte_nack <= nack_on;
      byte_in <= rd_val;
    end
  end
endmodule // phy_model

/* tb/pass_through_cmd_props.sv */
// port checker for the pass-through interpreter
// assumes one clock domain and synchronous active-low reset
module pass_through_cmd_props
  import pass_through_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       in_ready,
  input wire logic       out_valid,
  input wire logic [7:0] out_byte,
  input wire logic       out_last,
  input wire logic       out_ready,
  input wire logic       byte_req,
  input wire logic [7:0] byte_out,
  input wire logic       bad_command,
  input wire logic [5:0] spi_divisor
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  req_pulse_a:
    assert property (byte_req |=> !byte_req)
    else $error("byte request longer than one cycle");
  out_hold_a:
    assert property (out_valid && !out_ready |=> out_valid
      && $stable(out_byte) && $stable(out_last))
    else $error("reply byte dropped before accept");
  div_legal_a:
    assert property (spi_divisor inside {DIVISORS})
    else $error("divisor outside the fixed set");
  bad_quiet_a:
    assert property (bad_command |-> !out_valid && !byte_req)
    else $error("refused packet caused traffic");
  rst_clear_a:
    assert property (disable iff (1'b0) !rst_n |=>
      !byte_req && !out_valid && !in_ready)
    else $error("outputs active after reset");
  parse_excl_a:
    assert property (in_ready |-> !out_valid)
    else $error("accepting while replying");
  req_idle_a:
    assert property (byte_req |-> !in_ready)
    else $error("bus byte while parsing");
  last_valid_a:
    assert property (out_last |-> out_valid)
    else $error("last flag without valid");
  byte_stand_a:
    assert property ($changed(byte_out) |-> byte_req)
    else $error("bus byte changed without request");
  cover property (byte_req);
  cover property (out_last && out_ready);
  cover property (bad_command);
endmodule // pass_through_cmd_props
bind pass_through_cmd pass_through_cmd_props i_pass_through_cmd_props (
  .clk, .rst_n, .in_ready, .out_valid, .out_byte, .out_last, .out_ready,
  .byte_req, .byte_out, .bad_command, .spi_divisor);

/* tb/host_pass_through_bus_access_bench.sv */
// self-checking bench for the pass-through command interpreter
// assumes phy_model answers bus bytes and the checker is bound in
module host_pass_through_bus_access_bench
  import pass_through_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, in_valid = 1'b0, in_first = 1'b0;
  logic       out_ready = 1'b0, nack_on = 1'b0, drv_cpol = 1'b0;
  logic       drv_is_i2c = 1'b0, drv_three_wire = 1'b0, drv_cpha = 1'b0;
  logic       drv_cs_high = 1'b0, drv_low_bit_first = 1'b0, i2c;
  logic [3:0] bus_is_i2c = 4'h4;
  logic [7:0] in_byte = 8'h00, rd_val = 8'h00;
  logic       in_ready, out_valid, out_last, byte_req, byte_restart, byte_last;
  logic       spi_three_wire, spi_cpol, spi_cs_high, spi_low_bit_first;
  logic       byte_ack, byte_nack, bad_command, bad_seen, spi_cpha;
  logic [7:0] out_byte, byte_out, sensor_id, target, byte_in;
  logic [5:0] spi_divisor;
  logic [1:0] bus_select;
  logic [7:0] q[$], rx[$], e[$], seen[$];
  logic [1:0] rs[$];
  int         miscompares = 0, compares = 0, gap_cnt = 0, gap_last = 0;
  int         test_no = 1;
  always #20 clk = ~clk;
  pass_through_cmd i_pass_through_cmd (
    .clk, .rst_n, .in_valid, .in_byte, .in_first, .in_ready, .out_valid,
    .out_byte, .out_last, .out_ready, .bus_is_i2c, .drv_is_i2c,
    .drv_three_wire, .drv_cpol, .drv_cpha, .drv_cs_high,
    .drv_low_bit_first, .byte_req, .byte_out, .byte_last,
    .byte_restart, .bus_select, .spi_three_wire, .spi_cpol, .spi_cpha,
    .spi_cs_high, .spi_low_bit_first, .spi_divisor, .sensor_id, .target,
    .bad_command, .byte_ack, .byte_nack, .byte_in);
  phy_model i_phy_model (.clk, .byte_req, .nack_on, .rd_val, .byte_ack,
    .byte_nack, .byte_in);
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (byte_req === 1'b1)
    begin
      seen.push_back(byte_out);
      rs.push_back({byte_last, byte_restart});
      gap_last = gap_cnt;
    end
    gap_cnt = (byte_ack === 1'b1 || byte_nack === 1'b1) ? 0 : gap_cnt + 1;
    if (bad_command === 1'b1)
      bad_seen = 1'b1;
  end
  task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // st of zero marks a packet that must be refused without reply
  task automatic run(logic [15:0] code, mode, rate,
                     logic [7:0] fmt, tgt, cnt, rg, st);
    int n;
    q = {code[7:0], code[15:8], 8'h00, 8'h00, mode[7:0], mode[15:8],
         rate[7:0], rate[15:8], fmt, tgt, cnt, rg};
    for (int i = 0; mode[0] && i < cnt; i++)
      q.push_back(8'hA0 + i[7:0]);
    while (q.size() % 4 != 0)
      q.push_back(8'hEE);
    q[2] = 8'(q.size() - 4);
    seen = {};
    rs = {};
    rx = {};
    bad_seen = 1'b0;
    foreach (q[i])
    begin
      @(negedge clk);
      in_valid = 1'b1;
      in_byte = q[i];
      in_first = (i == 0);
      n = 0;
      @(posedge clk);
      while (in_ready !== 1'b1 && n++ < 9000)
        @(posedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
    // host stalls two cycles of four so held reply bytes are seen
    for (n = 0; n < (st != 8'h00 ? 20000 : 300); n++)
    begin
      @(negedge clk);
      out_ready = n[1];
      @(posedge clk);
      if (out_valid === 1'b1 && out_ready)
        rx.push_back(out_byte);
      if (out_valid === 1'b1 && out_ready && out_last === 1'b1)
        break;
    end
    i2c = mode[4:3] != 2'h0 && bus_is_i2c[mode[4:3]];
    e = {8'h05, 8'h00, 8'h00, 8'h00, st, mode[7:0], mode[15:8],
         i2c ? 8'h00 : rate[7:0], i2c ? 8'h00 : rate[15:8], fmt, tgt, cnt,
         rg};
    e[2] = 8'(((9 + cnt + 3) / 4) * 4);
    if (!mode[0] && st == 8'h01)
      e.push_back(rd_val);
    if (st == 8'h00)
    begin
      chk("refused reply", rx.size(), 0);
      chk("refused flag", bad_seen, 1);
      chk("refused bus", seen.size(), 0);
    end
    else
      foreach (e[i])
        if (!(i == 2 && (mode[0] || st != 8'h01)))
          chk("reply", i < rx.size() ? rx[i] : 8'hXX, e[i]);
    $display("test %0d done", test_no++);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    rd_val = 8'h5A;
    run(16'h000A, 16'hC4CD, 16'h1194, 8'hF1, 8'h05, 8'h02, 8'h11, 8'h01);
    chk("bytes", {seen[0], seen[1]}, 16'h22A0);
    chk("gap", gap_last inside {[4999:5001]}, 1);
    chk("divisor", spi_divisor, 6'h06);
    chk("bus", bus_select, 2'h1);
    chk("spi", {spi_three_wire, spi_cpol, spi_cpha, spi_cs_high,
        spi_low_bit_first}, 5'h0F);
    chk("target", target, 8'h05);
    run(16'h000A, 16'h0038, 16'hFFFF, 8'h90, 8'h02, 8'h01, 8'h03, 8'h01);
    chk("cmd byte", seen[0], 8'h13);
    chk("divisor", spi_divisor, 6'h02);
    chk("bus", bus_select, 2'h3);
    chk("three wire", spi_three_wire, 1);
    rd_val = 8'hC3;
    run(16'h000A, 16'h0010, 16'h1194, 8'h00, 8'h42, 8'h01, 8'h20, 8'h01);
    chk("i2c reg", seen[0], 8'h20);
    chk("restart", rs[rs.size() - 1], 2'h3);
    chk("target", target, 8'h42);
    run(16'h000B, 16'h0010, 16'h0000, 8'h00, 8'h42, 8'h01, 8'h20, 8'h00);
    run(16'h000A, 16'h0010, 16'h0000, 8'h00, 8'h42, 8'hF5, 8'h20, 8'h00);
    nack_on = 1'b1;
    run(16'h000A, 16'h0010, 16'h1194, 8'h00, 8'h42, 8'h01, 8'h20, 8'h02);
    nack_on = 1'b0;
    drv_cpol = 1'b1;
    run(16'h000A, 16'hC001, 16'h1194, 8'h07, 8'h09, 8'h01, 8'h30, 8'h01);
    chk("sensor id", sensor_id, 8'h07);
    chk("driver spi", {spi_cpol, spi_cs_high, spi_low_bit_first},
        3'h4);
    chk("bus", bus_select, 2'h0);
    final_report();
  end
  initial
  begin
    #(40 * 40000);
    miscompares++;
    final_report();
  end
endmodule // host_pass_through_bus_access_bench
